/* File: design/gpio_ports.sv */
// How it works
// RULE1 - five independent 8-bit ports, forty pins, each pin configured on its own
// RULE2 - software reaches every port by plain register reads and writes
// RULE3 - port data registers sit at F1H to F5H, all read/write
// RULE4 - port 0 pins use two-bit fields in high E0H and low E1H registers
// RULE5 - a port 0 pin in output mode is driven push-pull
// RULE6 - port 0 alternates: interrupt inputs, buzzer, analog inputs, Schmitt input
// RULE7 - high bits 7:6 pin 7: input, timer A, analog 7, output
// RULE8 - high bits 5:4 pin 6: input, timer B, analog 6, output
// RULE9 - high bits 3:2 pin 5: input, timer 0, analog 5, output
// RULE10 - high bits 1:0 pin 4: input, timer 1, analog 4, output
// RULE11 - writing 55H to port 0 high routes timers to pins 7..4 beside LCD
// RULE12 - port 1 offers inputs, pull-ups, push-pull, LCD capacitor and bias alternates
// RULE13 - reset clears port 1 high configuration to 00H, inputs
// RULE14 - reset clears port 1 low configuration to 00H, inputs
// RULE15 - port 2 offers LCD common and common-or-segment alternates
// RULE16 - port 2 high and low configuration reset to 00H, inputs
// RULE17 - an alternate works only when its peripheral is enabled too
// RULE18 - ports 3 and 4 add open drain; ports 0 and 3 have Schmitt inputs
// RULE19 - data read gives pad level for inputs, latch for outputs; writes set latch
// RULE20 - port 0 low register: bits 7:6 pin 3 down to 1:0 pin 0
`timescale 1ns/10ps
`include "gpio_map.svh"
module gpio_ports #(
  parameter int NUM_PORTS = `GPIO_NUM_PORTS,
  parameter int PORT_WIDTH = `GPIO_PORT_WIDTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // cpu register space
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // pads
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_in,
  output gpio_pkg::port_pins_t [NUM_PORTS-1:0] pin_ctrl,
  // on-chip peripherals
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] alt_out,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] alt_en,
  output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_level
);
  import gpio_pkg::*;

  localparam logic [7:0] DATA_ADDR [`GPIO_NUM_PORTS] = '{
    `GPIO_ADDR_PORT0_DATA,
    `GPIO_ADDR_PORT1_DATA,
    `GPIO_ADDR_PORT2_DATA,
    `GPIO_ADDR_PORT3_DATA,
    `GPIO_ADDR_PORT4_DATA
  }; // RULE3

  localparam logic [7:0] CFG_HI_ADDR [`GPIO_NUM_PORTS] = '{
    `GPIO_ADDR_PORT0_CFG_HI,
    `GPIO_ADDR_PORT1_CFG_HI,
    `GPIO_ADDR_PORT2_CFG_HI,
    `GPIO_ADDR_PORT3_CFG_HI,
    `GPIO_ADDR_PORT4_CFG_HI
  };

  localparam logic [7:0] CFG_LO_ADDR [`GPIO_NUM_PORTS] = '{
    `GPIO_ADDR_PORT0_CFG_LO,
    `GPIO_ADDR_PORT1_CFG_LO,
    `GPIO_ADDR_PORT2_CFG_LO,
    `GPIO_ADDR_PORT3_CFG_LO,
    `GPIO_ADDR_PORT4_CFG_LO
  };

  localparam logic [7:0] PULL_ADDR [`GPIO_NUM_PORTS] = '{
    `GPIO_ADDR_PORT0_PULL,
    `GPIO_ADDR_PORT1_PULL,
    `GPIO_ADDR_PORT2_PULL,
    `GPIO_ADDR_PORT3_PULL,
    `GPIO_ADDR_PORT4_PULL
  };

  // open-drain registers exist for the ports at and above the first capable one
  localparam logic [7:0] OD_ADDR [`GPIO_NUM_PORTS] = '{
    8'h00,
    8'h00,
    8'h00,
    `GPIO_ADDR_PORT3_OPEN_DRAIN,
    `GPIO_ADDR_PORT4_OPEN_DRAIN
  };

  initial
  begin
    if (NUM_PORTS != `GPIO_NUM_PORTS)
      $error("gpio_ports serves exactly five ports");
    if (PORT_WIDTH != `GPIO_PORT_WIDTH)
      $error("gpio_ports serves 8-bit ports only");
  end

  // per-port software state
  logic [7:0] data_q [NUM_PORTS];
  logic [7:0] cfg_hi_q [NUM_PORTS];
  logic [7:0] cfg_lo_q [NUM_PORTS];
  logic [7:0] pull_q [NUM_PORTS];
  logic [7:0] od_q [NUM_PORTS];

  // decode results
  logic [NUM_PORTS-1:0] data_hit;
  logic [NUM_PORTS-1:0] cfg_hi_hit;
  logic [NUM_PORTS-1:0] cfg_lo_hit;
  logic [NUM_PORTS-1:0] pull_hit;
  logic [NUM_PORTS-1:0] od_hit;
  logic [7:0] port_read [NUM_PORTS];
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] level_sync;

  logic [7:0] reg_rdata_d;
  logic any_hit;

  // every pad input is synchronised before any logic looks at it
  pin_sync #(
    .WIDTH(NUM_PORTS * PORT_WIDTH)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(pin_in),
    .sync_out(level_sync)
  ); // RULE18

  assign pin_level = level_sync;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      localparam bit OD_CAPABLE = (p >= `GPIO_FIRST_OD_PORT);
      port_setup_t setup;

      assign data_hit[p] = (reg_addr == DATA_ADDR[p]); // RULE2
      assign cfg_hi_hit[p] = (reg_addr == CFG_HI_ADDR[p]); // RULE4
      assign cfg_lo_hit[p] = (reg_addr == CFG_LO_ADDR[p]);
      assign pull_hit[p] = (reg_addr == PULL_ADDR[p]);
      assign od_hit[p] = OD_CAPABLE && (reg_addr == OD_ADDR[p]);

      // data latch takes writes in every mode
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          data_q[p] <= `GPIO_DATA_RESET;
        else if (reg_wr_en && data_hit[p])
          data_q[p] <= reg_wdata; // RULE19
      end

      // configuration resets to all inputs
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cfg_hi_q[p] <= `GPIO_CFG_RESET; // RULE13 RULE16
          cfg_lo_q[p] <= `GPIO_CFG_RESET; // RULE14 RULE16
        end
        else
        begin
          if (reg_wr_en && cfg_hi_hit[p])
            cfg_hi_q[p] <= reg_wdata; // RULE11
          if (reg_wr_en && cfg_lo_hit[p])
            cfg_lo_q[p] <= reg_wdata; // RULE20
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pull_q[p] <= `GPIO_PULL_RESET;
          od_q[p] <= `GPIO_OPEN_DRAIN_RESET;
        end
        else
        begin
          if (reg_wr_en && pull_hit[p])
            pull_q[p] <= reg_wdata; // RULE12
          if (reg_wr_en && od_hit[p])
            od_q[p] <= reg_wdata; // RULE18
        end
      end

      assign setup.cfg_hi = cfg_hi_q[p];
      assign setup.cfg_lo = cfg_lo_q[p];
      assign setup.latch = data_q[p];
      assign setup.pull = pull_q[p];
      assign setup.open_drain = od_q[p];

      // timer, analog, interrupt, buzzer and LCD alternates share the mux
      port_pin_mux #(
        .OPEN_DRAIN_CAPABLE(OD_CAPABLE)
      ) u_mux (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .setup(setup),
        .pin_level(level_sync[p]),
        .alt_out(alt_out[p]),
        .alt_en(alt_en[p]),
        .pins(pin_ctrl[p]),
        .read_val(port_read[p])
      ); // RULE1 RULE6 RULE9 RULE10 RULE15
    end
  endgenerate

  assign any_hit = |{data_hit, cfg_hi_hit, cfg_lo_hit, pull_hit, od_hit};

  // read mux, unmapped addresses return zero
  always_comb
  begin
    reg_rdata_d = `GPIO_RDATA_UNMAPPED;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (data_hit[i])
        reg_rdata_d = reg_rdata_d | port_read[i]; // RULE19
      if (cfg_hi_hit[i])
        reg_rdata_d = reg_rdata_d | cfg_hi_q[i];
      if (cfg_lo_hit[i])
        reg_rdata_d = reg_rdata_d | cfg_lo_q[i];
      if (pull_hit[i])
        reg_rdata_d = reg_rdata_d | pull_q[i];
      if (od_hit[i])
        reg_rdata_d = reg_rdata_d | od_q[i];
    end
    if (!any_hit)
      reg_rdata_d = `GPIO_RDATA_UNMAPPED;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= `GPIO_RDATA_UNMAPPED;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
        reg_rdata <= reg_rdata_d; // RULE2
    end
  end

endmodule

/* File: design/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  initial
  begin
    if (WIDTH < 1)
      $error("pin_sync width must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

/* File: design/port_pin_mux.sv */
`timescale 1ns/10ps
module port_pin_mux #(
  parameter bit OPEN_DRAIN_CAPABLE = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // software settings
  input wire gpio_pkg::port_setup_t setup,
  // synchronised pad levels
  input wire logic [7:0] pin_level,
  // peripheral side
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_en,
  // pad controls and read-back
  output gpio_pkg::port_pins_t pins,
  output logic [7:0] read_val
);
  import gpio_pkg::*;

  logic [15:0] cfg_all;
  port_pins_t pins_d;

  assign cfg_all = {setup.cfg_hi, setup.cfg_lo};

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      pin_mode_t mode;
      wire od_sel = OPEN_DRAIN_CAPABLE & setup.open_drain[i];
      wire out_val = (mode == MODE_ALT_OUT) ? alt_out[i] : setup.latch[i];
      // alternate roles act only with the peripheral enabled
      wire alt_live = alt_en[i]; // RULE17
      wire drives = (mode == MODE_PUSH_PULL) || ((mode == MODE_ALT_OUT) && alt_live);
      assign mode = pin_mode_t'(cfg_all[2*i+1 -: 2]); // RULE4 RULE20
      assign pins_d.out[i] = out_val; // RULE5
      // open drain pulls low only, high is released to the pull-up
      assign pins_d.oe_n[i] = !(drives && !(od_sel && out_val)); // RULE18
      assign pins_d.pull_en[i] = setup.pull[i] && !(drives && !od_sel) &&
                                 (mode != MODE_ALT_ANALOG);
      assign pins_d.analog_sel[i] = (mode == MODE_ALT_ANALOG) && alt_live; // RULE7 RULE8
      // output pins read their latch, all others the pad
      assign read_val[i] = (mode == MODE_PUSH_PULL) ? setup.latch[i] : pin_level[i]; // RULE19
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pins <= '{out: 8'h00, oe_n: 8'hFF, pull_en: 8'h00, analog_sel: 8'h00};
    else
      pins <= pins_d;
  end

endmodule

/* File: shared/gpio_map.svh */
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// port data registers
`define GPIO_ADDR_PORT0_DATA 8'hF1
`define GPIO_ADDR_PORT1_DATA 8'hF2
`define GPIO_ADDR_PORT2_DATA 8'hF3
`define GPIO_ADDR_PORT3_DATA 8'hF4
`define GPIO_ADDR_PORT4_DATA 8'hF5

// pin configuration registers, high byte pins 7..4, low byte pins 3..0
`define GPIO_ADDR_PORT0_CFG_HI 8'hE0
`define GPIO_ADDR_PORT0_CFG_LO 8'hE1
`define GPIO_ADDR_PORT1_CFG_HI 8'hE2
`define GPIO_ADDR_PORT1_CFG_LO 8'hE3
`define GPIO_ADDR_PORT2_CFG_HI 8'hE4
`define GPIO_ADDR_PORT2_CFG_LO 8'hE5
`define GPIO_ADDR_PORT3_CFG_HI 8'hE6
`define GPIO_ADDR_PORT3_CFG_LO 8'hE7
`define GPIO_ADDR_PORT4_CFG_HI 8'hEE
`define GPIO_ADDR_PORT4_CFG_LO 8'hEF

// pull-up enables
`define GPIO_ADDR_PORT0_PULL 8'hE8
`define GPIO_ADDR_PORT1_PULL 8'hE9
`define GPIO_ADDR_PORT2_PULL 8'hDF
`define GPIO_ADDR_PORT3_PULL 8'hEC
`define GPIO_ADDR_PORT4_PULL 8'hED

// open-drain select, ports 3 and 4 only
`define GPIO_ADDR_PORT3_OPEN_DRAIN 8'hEA
`define GPIO_ADDR_PORT4_OPEN_DRAIN 8'hF0

// reset values
`define GPIO_CFG_RESET 8'h00
`define GPIO_DATA_RESET 8'h00
`define GPIO_PULL_RESET 8'h00
`define GPIO_OPEN_DRAIN_RESET 8'h00
`define GPIO_RDATA_UNMAPPED 8'h00

// geometry
`define GPIO_NUM_PORTS 5
`define GPIO_PORT_WIDTH 8
`define GPIO_FIRST_OD_PORT 3

`endif

/* File: shared/gpio_pkg.sv */
package gpio_pkg;

  // two-bit pin mode, same layout in every configuration register
  typedef enum logic [1:0] {
    MODE_INPUT = 2'b00,
    MODE_ALT_OUT = 2'b01,
    MODE_ALT_ANALOG = 2'b10,
    MODE_PUSH_PULL = 2'b11
  } pin_mode_t;

  // per-port drive controls towards the pad ring
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull_en;
    logic [7:0] analog_sel;
  } port_pins_t;

  // per-port software settings handed to the pin mux
  typedef struct packed {
    logic [7:0] cfg_hi;
    logic [7:0] cfg_lo;
    logic [7:0] latch;
    logic [7:0] pull;
    logic [7:0] open_drain;
  } port_setup_t;

endpackage

/* File: testbench/bit_programmable_io_ports_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module bit_programmable_io_ports_bench;
  import gpio_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr_en = 1'h0;
  logic reg_rd_en = 1'h0;
  logic [7:0] rdata, got_e, d, e;
  logic rd_valid;
  logic [4:0][7:0] pin_in, pin_level, alt_out = '0, alt_en = '0, ext_val = '0, ext_drv = '1;
  port_pins_t [4:0] pin_ctrl;
  logic [7:0] cfg [5] = '{8'hE0, 8'hE2, 8'hE4, 8'hE6, 8'hEE};
  logic [7:0] exp_q [$];
  int num_errors = 0;
  int n_checks = 0;
  int p;
  integer seed = 32'h8fd39302;
  always #2 ref_clk = ~ref_clk;
  gpio_ports gpio_ports_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(rdata),
    .reg_rd_valid(rd_valid), .pin_in(pin_in), .pin_ctrl(pin_ctrl), .alt_out(alt_out),
    .alt_en(alt_en), .pin_level(pin_level));
  pad_model pad_model_i (.ref_clk(ref_clk), .pin_ctrl(pin_ctrl), .ext_val(ext_val),
    .ext_drv(ext_drv), .pin_in(pin_in));
  // one register access; a read notes what it expects
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    if (!w)
      exp_q.push_back(v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr_en <= w;
    reg_rd_en <= !w;
    @(posedge ref_clk);
    reg_wr_en <= 1'h0;
    reg_rd_en <= 1'h0;
  endtask
  // pad controls once the settings have landed; out only where driven
  task automatic pins(input int q, input logic [7:0] oe, input logic [7:0] o,
    input logic [7:0] an);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("oe_n", oe, pin_ctrl[q].oe_n)
    `CHK("out", o & ~oe, pin_ctrl[q].out & ~oe)
    `CHK("analog_sel", an, pin_ctrl[q].analog_sel)
  endtask
  task automatic close_out;
    for (int i = 0; i < 20 && exp_q.size() > 0; i++)
      @(posedge ref_clk);
    if (exp_q.size() > 0)
      num_errors++;
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk)
    if (rd_valid === 1'h1)
    begin
      got_e = exp_q.pop_front();
      `CHK("rdata", got_e, rdata)
    end
  initial
  begin
    #100000;
    num_errors++;
    close_out;
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 6; i++)
      bus(1'h0, 8'hE0 + i[7:0], 8'h00);
    pins(2, 8'hFF, 8'h00, 8'h00);
    @(posedge ref_clk);
    alt_en <= '1;
    for (int m = 0; m < 4; m++)
    begin
      d = 8'($random(seed));
      alt_out[0] <= d;
      bus(1'h1, 8'hE0, {4{m[1:0]}});
      bus(1'h1, 8'hE1, {4{m[1:0]}});
      bus(1'h1, 8'hF1, ~d);
      pins(0, m[0] ? 8'h00 : 8'hFF, m == 1 ? d : ~d, m == 2 ? 8'hFF : 8'h00);
      bus(1'h0, 8'hE0, {4{m[1:0]}});
    end
    alt_en[0] <= 8'h00;
    bus(1'h1, 8'hE0, 8'h55);
    pins(0, 8'hF0, ~d, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      p = {$random(seed)} % 5;
      d = 8'($random(seed));
      e = 8'($random(seed));
      bus(1'h1, cfg[p], 8'hFF);
      bus(1'h1, cfg[p] + 8'h01, 8'hFF);
      bus(1'h1, 8'hF1 + p[7:0], d);
      pins(p, 8'h00, d, 8'h00);
      bus(1'h0, 8'hF1 + p[7:0], d);
      ext_val[p] <= e;
      bus(1'h1, cfg[p], 8'h00);
      bus(1'h1, cfg[p] + 8'h01, 8'h00);
      pins(p, 8'hFF, 8'h00, 8'h00);
      `CHK("pin_level", e, pin_level[p])
      bus(1'h0, 8'hF1 + p[7:0], e);
    end
    ext_drv[1] <= 8'h0F;
    bus(1'h1, 8'hE9, 8'hF0);
    pins(1, 8'hFF, 8'h00, 8'h00);
    `CHK("pull_en", 8'hF0, pin_ctrl[1].pull_en)
    bus(1'h0, 8'hF2, {4'hF, ext_val[1][3:0]});
    bus(1'h1, 8'hEA, 8'hFF);
    bus(1'h1, 8'hE6, 8'hFF);
    bus(1'h1, 8'hE7, 8'hFF);
    bus(1'h1, 8'hF4, 8'h0F);
    pins(3, 8'h0F, 8'h00, 8'h00);
    bus(1'h1, 8'h10, 8'hA5);
    bus(1'h0, 8'h10, 8'h00);
    close_out;
  end
endmodule

/* File: testbench/gpio_ports_properties.sv */
`timescale 1ns/10ps
module gpio_ports_properties #(
  parameter int NUM_PORTS = 5,
  parameter int PORT_WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register space
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  // pads and peripherals
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_in,
  input wire gpio_pkg::port_pins_t [NUM_PORTS-1:0] pin_ctrl,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] alt_out,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] alt_en,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_level
);
  import gpio_pkg::*;
  logic [1:0] up_q;
  // edges since reset release, saturating
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_answer; reg_rd_en |=> reg_rd_valid; endproperty
  property p_rd_quiet; !reg_rd_en |=> !reg_rd_valid; endproperty
  property p_rd_hold; !reg_rd_en |=> $stable(reg_rdata); endproperty
  property p_unmapped; reg_rd_en && reg_addr == 8'h10 |=> reg_rdata == 8'h00; endproperty
  property p_pp_cfg;
    reg_wr_en && reg_addr == 8'hE0 && reg_wdata == 8'hFF ##1 !reg_wr_en
      |=> pin_ctrl[0].oe_n[7:4] == 4'h0;
  endproperty
  property p_sync; up_q == 2'h3 |-> pin_level == $past(pin_in, 2); endproperty
  property p_reset_in;
    $rose(rst_n) |-> (pin_ctrl[1].oe_n & pin_ctrl[2].oe_n) == 8'hFF;
  endproperty
  property p_alt_gate; (pin_ctrl[0].analog_sel & ~$past(alt_en[0])) == 8'h00; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_pp_cfg: assert property (p_pp_cfg) else $error("push-pull not driven");
  a_sync: assert property (p_sync) else $error("pin level not two edges late");
  a_reset_in: assert property (p_reset_in) else $error("pins not input after reset");
  a_alt_gate: assert property (p_alt_gate) else $error("analog without enable");
  c_read: cover property (reg_rd_en && reg_addr == 8'hF1);
  c_analog: cover property (pin_ctrl[0].analog_sel != 8'h00);
  c_drive3: cover property (pin_ctrl[3].oe_n != 8'hFF);
endmodule
bind gpio_ports gpio_ports_properties #(.NUM_PORTS(NUM_PORTS), .PORT_WIDTH(PORT_WIDTH)) props_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .pin_in(pin_in), .pin_ctrl(pin_ctrl), .alt_out(alt_out),
  .alt_en(alt_en), .pin_level(pin_level));

/* File: testbench/pad_model.sv */
`timescale 1ns/10ps
module pad_model #(
  parameter int NUM_PORTS = 5
) (
  // clock
  input wire logic ref_clk,
  // block drive and outside sources
  input wire gpio_pkg::port_pins_t [NUM_PORTS-1:0] pin_ctrl,
  input wire logic [NUM_PORTS-1:0][7:0] ext_val,
  input wire logic [NUM_PORTS-1:0][7:0] ext_drv,
  // resolved pad levels
  output logic [NUM_PORTS-1:0][7:0] pin_in
);
  import gpio_pkg::*;
  logic tog_q = 1'h0;
  // a floating pin without pull shows a level that keeps changing
  always @(posedge ref_clk)
    tog_q <= ~tog_q;
  always_comb
    for (int p = 0; p < NUM_PORTS; p++)
      for (int b = 0; b < 8; b++)
        pin_in[p][b] = !pin_ctrl[p].oe_n[b] ? pin_ctrl[p].out[b] :
          ext_drv[p][b] ? ext_val[p][b] : pin_ctrl[p].pull_en[b] ? 1'h1 : tog_q;
endmodule
